/* src/ucg_defs.vh */
// Overview of operation
// R1 - Five clock modes: async, double, sync master/slave, SPI
// R2 - Rate generator clocks async, sync master, SPI
// R3 - Async divisor: integer 15:6, fraction 5:0
// R4 - Sync rate uses integer field, divide by two
// R5 - Samples per bit 16, 8, or 2
// R6 - Bit rate from divisor and peripheral clock
// R7 - Slave clock from pin, synchronised, edge-detected
// R8 - Peer keeps slave clock below quarter clock
// R9 - Peer holds each clock phase two samples
// R10 - Double speed doubles rate, eight samples
// R11 - Clock pin output as master, input slave
// R12 - Sample on edge opposite data change
// R13 - No inversion: change rising, sample falling
// R14 - SPI master acts as sync master
// R15 - SPI modes from inversion and phase
// R16 - Leading edge first, trailing edge last
// R17 - Software keeps phase and inversion during transfers
// R18 - Runs during debug halt unless configured
// R19 - Full-duplex setup order for software
// R20 - One-wire setup order, optional open drain
// R21 - Software quiesces before re-initialising
// R22 - Fraction by accumulator adding extra cycle
`ifndef UCG_DEFS_VH
`define UCG_DEFS_VH
`define UCG_BAUD_W        16
`define UCG_INT_MSB       15
`define UCG_INT_LSB       6
`define UCG_FRAC_MSB      5
`define UCG_FRAC_W        6
`define UCG_SPB_NORMAL    5'h10
`define UCG_SPB_DOUBLE    5'h08
`define UCG_SPB_SYNC      5'h02
`define UCG_MODE_ASYNC    2'h0
`define UCG_MODE_SYNC     2'h1
`define UCG_MODE_SPI      2'h3
`define UCG_RXM_NORMAL    1'h0
`define UCG_RXM_DOUBLE    1'h1
`endif

/* src/ucg_clock_gen.v */
`timescale 1ns/1ps
`include "ucg_defs.vh"
module ucg_clock_gen (
    input  wire        clk_in,
    input  wire        rst_n_in,
    input  wire [15:0] baud_divisor_in,
    input  wire [1:0]  communication_mode_in,
    input  wire        receiver_speed_mode_in,
    input  wire        sync_master_in,
    input  wire        pin_inversion_in,
    input  wire        spi_clock_phase_in,
    input  wire        debug_halt_in,
    input  wire        halt_in_debug_in,
    input  wire        transfer_clock_pin_in,
    output wire        transfer_clock_pin_out,
    output wire        transfer_clock_pin_oe_out,
    output reg         sample_tick_out,
    output reg         txclk_out,
    output reg         rxclk_out,
    output wire [4:0]  samples_per_bit_out
);

    // ************************************************************
    // Mode decode
    // ************************************************************
    // Code 2 is unused; it falls back on the bit-0 decode and acts as async
    reg        is_sync;
    reg        is_spi;
    reg        use_intern;
    always @* begin
        is_sync    = 1'b0;
        is_spi     = 1'b0;
        use_intern = 1'b1;
        case (communication_mode_in)
            `UCG_MODE_ASYNC: begin
                is_sync    = 1'b0;                                            // R1
                use_intern = 1'b1;                                            // R2
            end
            `UCG_MODE_SYNC: begin
                is_sync    = 1'b1;                                            // R1
                use_intern = sync_master_in;                                  // R2
            end
            `UCG_MODE_SPI: begin
                is_sync    = 1'b1;
                is_spi     = 1'b1;                                            // R1
                use_intern = 1'b1;                                            // R14
            end
            default: begin
                is_sync    = communication_mode_in[0];
                use_intern = ~communication_mode_in[0] | sync_master_in;
            end
        endcase
    end

    wire       run       = ~(debug_halt_in & halt_in_debug_in);               // R18
    wire       gen_on    = run & use_intern;
    wire       drive_pin = is_sync & use_intern;
    wire [9:0] int_part  = baud_divisor_in[`UCG_INT_MSB:`UCG_INT_LSB];        // R3
    wire [5:0] frac_part = baud_divisor_in[`UCG_FRAC_MSB:0];

    // ************************************************************
    // Samples per bit
    // ************************************************************
    reg  [4:0] spb_sel;
    always @* begin
        spb_sel = `UCG_SPB_NORMAL;
        case ({is_sync, receiver_speed_mode_in})
            2'b00: begin
                spb_sel = `UCG_SPB_NORMAL;                                    // R5
            end
            2'b01: begin
                spb_sel = `UCG_SPB_DOUBLE;                                    // R10
            end
            default: begin
                spb_sel = `UCG_SPB_SYNC;                                      // R5
            end
        endcase
    end

    assign samples_per_bit_out = spb_sel;

    // ************************************************************
    // Fractional rate generator
    // ************************************************************
    // Async: one sample tick per divisor/64 clocks, so a bit of S ticks gives
    // 64*f/(S*divisor). Sync: one toggle per integer field, a period of 2*int.
    // A zero integer field would stall the counter, so it acts as one.
    reg  [9:0] cnt_ff;
    reg  [5:0] acc_ff;
    reg        extra_ff;
    reg  [9:0] nxt_cnt;
    reg  [5:0] nxt_acc;
    reg        nxt_extra;
    wire [6:0] acc_sum  = {1'b0, acc_ff} + {1'b0, frac_part};
    wire [9:0] int_eff  = (int_part == 10'h000) ? 10'h001 : int_part;
    wire [9:0] period   = (~is_sync & extra_ff) ? int_eff : int_eff - 10'h001;
    wire       gen_tick = gen_on & (cnt_ff >= period);                        // R6

    always @* begin
        nxt_cnt   = cnt_ff;
        nxt_acc   = acc_ff;
        nxt_extra = extra_ff;
        if (!gen_on) begin
            nxt_cnt   = 10'h000;
            nxt_acc   = 6'h00;
            nxt_extra = 1'b0;
        end else if (gen_tick) begin
            nxt_cnt = 10'h000;
            if (!is_sync) begin
                nxt_acc   = acc_sum[5:0];                                     // R22
                nxt_extra = acc_sum[6];                                       // R22
            end else begin
                nxt_acc   = 6'h00;                                            // R4
                nxt_extra = 1'b0;
            end
        end else begin
            nxt_cnt = cnt_ff + 10'h001;
        end
    end

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_ff   <= 10'h000;
            acc_ff   <= 6'h00;
            extra_ff <= 1'b0;
        end else begin
            cnt_ff   <= nxt_cnt;
            acc_ff   <= nxt_acc;
            extra_ff <= nxt_extra;
        end
    end

    // ************************************************************
    // Internal bit clock and pin drive
    // ************************************************************
    reg  tclk_int_ff;
    reg  nxt_tclk_int;
    always @* begin
        nxt_tclk_int = tclk_int_ff;
        if (!drive_pin) begin
            nxt_tclk_int = 1'b0;
        end else if (gen_tick) begin
            nxt_tclk_int = ~tclk_int_ff;                                      // R4
        end
    end

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tclk_int_ff <= 1'b0;
        end else begin
            tclk_int_ff <= nxt_tclk_int;
        end
    end

    // Inversion applies at the pin, as a port inverter would
    assign transfer_clock_pin_out    = tclk_int_ff ^ pin_inversion_in;        // R13
    assign transfer_clock_pin_oe_out = drive_pin;                             // R11

    // ************************************************************
    // Slave clock synchroniser
    // ************************************************************
    // Edge detection is only reliable while the peer honours the quarter rate.
    // Stages 0 and 1 synchronise; stage 2 keeps the previous level.
    reg  [2:0] tclk_sync_ff;
    wire [2:0] sync_src = {tclk_sync_ff[1:0], transfer_clock_pin_in};         // R7
    wire       tclk_s2  = tclk_sync_ff[1];
    wire       tclk_s3  = tclk_sync_ff[2];
    genvar     gi;

    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
            always @(posedge clk_in or negedge rst_n_in) begin
                if (!rst_n_in) begin
                    tclk_sync_ff[gi] <= 1'b0;
                end else begin
                    tclk_sync_ff[gi] <= sync_src[gi];                         // R7
                end
            end
        end
    endgenerate

    // ************************************************************
    // Edge selection
    // ************************************************************
    // Edges are seen at the pin level (after inversion) in both roles.
    reg  pin_lvl;
    reg  new_lvl;
    reg  edge_now;
    always @* begin
        if (use_intern) begin
            pin_lvl  = tclk_int_ff ^ pin_inversion_in;
            edge_now = gen_tick;
            new_lvl  = ~pin_lvl;
        end else begin
            pin_lvl  = tclk_s2;
            edge_now = tclk_s2 ^ tclk_s3;
            new_lvl  = tclk_s2;
        end
    end

    wire rise = edge_now & new_lvl;
    wire fall = edge_now & ~new_lvl;

    // Leading edge is the one leaving the idle level
    reg  lead;
    reg  trail;
    always @* begin
        if (pin_inversion_in) begin
            lead  = fall;                                                     // R16
            trail = rise;
        end else begin
            lead  = rise;                                                     // R16
            trail = fall;
        end
    end

    localparam [2:0] sel_spi_mode0 = 3'h4;
    localparam [2:0] sel_spi_mode1 = 3'h5;
    localparam [2:0] sel_spi_mode2 = 3'h6;
    localparam [2:0] sel_spi_mode3 = 3'h7;

    reg  tx_e;
    reg  rx_e;
    always @* begin
        tx_e = rise;
        rx_e = fall;
        case ({is_spi, pin_inversion_in, spi_clock_phase_in})
            3'h0, 3'h1: begin
                tx_e = rise;                                                  // R13
                rx_e = fall;                                                  // R12
            end
            3'h2, 3'h3: begin
                tx_e = fall;                                                  // R13
                rx_e = rise;                                                  // R12
            end
            sel_spi_mode0, sel_spi_mode2: begin
                tx_e = trail;                                                 // R15
                rx_e = lead;                                                  // R15
            end
            sel_spi_mode1, sel_spi_mode3: begin
                tx_e = lead;                                                  // R15
                rx_e = trail;                                                 // R15
            end
            default: begin
                tx_e = rise;
                rx_e = fall;
            end
        endcase
    end

    // ************************************************************
    // Output strobes
    // ************************************************************
    // Registered so the transmitter and receiver see clean one-cycle pulses
    reg  nxt_sample_tick;
    reg  nxt_txclk;
    reg  nxt_rxclk;
    always @* begin
        nxt_sample_tick = 1'b0;
        nxt_txclk       = 1'b0;
        nxt_rxclk       = 1'b0;
        if (!is_sync) begin
            nxt_sample_tick = gen_tick;                                       // R3 R10
        end else if (run) begin
            nxt_txclk = tx_e;
            nxt_rxclk = rx_e;
        end
    end

    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sample_tick_out <= 1'b0;
            txclk_out       <= 1'b0;
            rxclk_out       <= 1'b0;
        end else begin
            sample_tick_out <= nxt_sample_tick;
            txclk_out       <= nxt_txclk;
            rxclk_out       <= nxt_rxclk;
        end
    end

    // ************************************************************
    // Limitations
    // ************************************************************
    // Mode, phase and inversion are used live; changing them mid-transfer
    // produces a stray edge, which the software side must avoid.

endmodule

/* testbench/ucg_clock_gen_assertions.sv */
`timescale 1ns/1ps
module ucg_chk (
    input wire        clk_in, rst_n_in, sync_master_in, pin_inversion_in, spi_clock_phase_in,
    input wire        debug_halt_in, halt_in_debug_in, transfer_clock_pin_in, transfer_clock_pin_out,
    input wire        transfer_clock_pin_oe_out, sample_tick_out, txclk_out, rxclk_out,
    input wire [15:0] baud_divisor_in,
    input wire [1:0]  communication_mode_in
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    logic [15:0] gap_ff;
    logic        seen_ff, pin_ff;
    wire         syn = communication_mode_in == 2'h1;
    wire         spi = communication_mode_in == 2'h3;
    wire         frz = debug_halt_in & halt_in_debug_in;
    wire         flp = transfer_clock_pin_out ^ pin_inversion_in;
    wire  [15:0] n   = (baud_divisor_in[15:6] == 10'h0) ? 16'h1 : {6'h0, baud_divisor_in[15:6]};
    wire         ev  = transfer_clock_pin_oe_out ? pin_ff != transfer_clock_pin_out : sample_tick_out;
    // First gap after reset or a freeze has no known start, so it is not judged
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            gap_ff  <= 16'h0;
            seen_ff <= 1'b0;
            pin_ff  <= pin_inversion_in;
        end else begin
            gap_ff  <= ev ? 16'h1 : gap_ff + 16'h1;
            seen_ff <= (seen_ff | ev) & ~frz;
            pin_ff  <= transfer_clock_pin_out;
        end
    end
    pin_dir_a: assert property (transfer_clock_pin_oe_out == (spi | syn & sync_master_in))
        else $error("pin direction");
    strobe_excl_a: assert property (!(txclk_out && rxclk_out)) else $error("tx and rx together");
    sync_edge_a: assert property (syn && transfer_clock_pin_oe_out && $changed(transfer_clock_pin_out)
        |-> (flp ? txclk_out : rxclk_out)) else $error("sync edge");
    spi_edge_a: assert property (spi && $changed(transfer_clock_pin_out)
        |-> (flp ^ spi_clock_phase_in ? rxclk_out : txclk_out)) else $error("spi edge");
    slave_clk_a: assert property (syn && !sync_master_in && $changed(transfer_clock_pin_in)
        |-> ##[2:4] (txclk_out || rxclk_out)) else $error("slave strobe");
    sync_rate_a: assert property (transfer_clock_pin_oe_out && ev && seen_ff |-> gap_ff == n)
        else $error("sync rate");
    async_rate_a: assert property (!communication_mode_in[0] && ev && seen_ff
        |-> gap_ff - n <= {15'h0, |baud_divisor_in[5:0]}) else $error("async rate");
    halt_quiet_a: assert property (frz [*2] |-> !(sample_tick_out || txclk_out || rxclk_out))
        else $error("halt");
    cover property (ev && seen_ff && !communication_mode_in[0]);
    cover property (spi && ev && seen_ff);
    cover property (syn && !sync_master_in && txclk_out);
endmodule
bind ucg_clock_gen ucg_chk chk_u (.*);

/* testbench/ucg_peer.sv */
`timescale 1ns/1ps
module ucg_peer (
    input  wire  run_in,
    output logic sck_out
);
    // 52 ns period is above four clocks; idles low between frames
    initial sck_out = 1'b0;
    always begin
        #26;
        sck_out = run_in ? ~sck_out : 1'b0;
    end
endmodule

/* testbench/tb.sv */
`timescale 1ns/1ps
module tb;
    logic        clk_in, rst_n_in, rxm, mst, inv, ph, dbg, hid, run, pp;
    logic [15:0] baud;
    logic [1:0]  cm;
    wire         pin, pout, oe, tick, tx, rx;
    wire  [4:0]  spb;
    int          errors = 0, total_checks = 0, cyc = 0, nev = 0, ntx = 0, nrx = 0, c;
    ucg_clock_gen dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .baud_divisor_in(baud),
        .communication_mode_in(cm), .receiver_speed_mode_in(rxm), .sync_master_in(mst),
        .pin_inversion_in(inv), .spi_clock_phase_in(ph), .debug_halt_in(dbg), .halt_in_debug_in(hid),
        .transfer_clock_pin_in(pin), .transfer_clock_pin_out(pout), .transfer_clock_pin_oe_out(oe),
        .sample_tick_out(tick), .txclk_out(tx), .rxclk_out(rx), .samples_per_bit_out(spb));
    ucg_peer peer_u (.run_in(run), .sck_out(pin));
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // Counted just after the edge so registered strobes have landed
    always @(posedge clk_in) begin
        #1;
        cyc++;
        if (oe ? pout !== pp : tick === 1'b1) nev++;
        if (tx === 1'b1) ntx++;
        if (rx === 1'b1) nrx++;
        pp = pout;
        if (cyc == 5000) begin
            errors++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic cfg(input logic [15:0] b, input logic [1:0] m, input logic [3:0] f);
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        baud <= b;
        cm <= m;
        {rxm, mst, inv, ph} <= f;
        repeat (10) @(posedge clk_in);
        rst_n_in <= 1'b1;
    endtask
    task automatic meas(input int k, input int exp);
        int s;
        for (int i = 0; i <= k; i++) begin
            s = (i == 1) ? cyc : s;
            c = nev;
            while (nev == c) begin
                @(posedge clk_in);
                #2;
            end
        end
        chk(cyc - s, exp);
        $display("test end, mode %0h", cm);
        @(posedge clk_in);
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        {rst_n_in, rxm, mst, inv, ph, dbg, hid, run, pp} = 9'h0;
        {baud, cm} = 18'h0;
        cfg(16'h0100, 2'h0, 4'h0);
        chk(spb, 32'h10);
        meas(50, 200);
        cfg(16'h0120, 2'h0, 4'h8);
        chk(spb, 32'h8);
        meas(50, 225);
        dbg <= 1'b1;
        hid <= 1'b1;
        repeat (3) @(posedge clk_in);
        c = nev;
        repeat (40) @(posedge clk_in);
        chk(nev - c, 0);
        hid <= 1'b0;
        meas(10, 45);
        dbg <= 1'b0;
        cfg(16'h00C0, 2'h1, 4'h4);
        chk(oe, 32'h1);
        chk(spb, 32'h2);
        meas(20, 60);
        for (int i = 0; i < 4; i++) begin
            cfg(16'h0080, 2'h3, i[3:0]);
            chk(oe, 32'h1);
            meas(8, 16);
        end
        cfg(16'h0040, 2'h1, 4'h0);
        chk(oe, 32'h0);
        ntx = 0;
        nrx = 0;
        run <= 1'b1;
        repeat (10) @(posedge pin);
        @(posedge clk_in);
        run <= 1'b0;
        repeat (10) @(posedge clk_in);
        chk(ntx, 32'd10);
        chk(nrx, 32'd10);
        $display("test end, slave");
        report_and_stop();
    end
endmodule
